// File: pkg/uart_regs_cfg.svh
// Address map, field positions, reset values and codes of the UART register block
`ifndef UART_REGS_CFG_SVH
`define UART_REGS_CFG_SVH

`define RST_BYTE 8'h00
`define LCR_ENH_KEY 8'hBF
`define LCR_DLAB_BIT 7
`define EFR_ENH_BIT 4
`define FEATURE_CONTROL_SWAP_BIT 6
`define FEATURE_CONTROL_MODE_BIT 7
`define FEATURE_CONTROL_TTAB_HI 5
`define FEATURE_CONTROL_TTAB_LO 4
`define FEATURE_CONTROL_TTAB_PROG 2'h3

`define A_DATA 3'h0
`define A_IER 3'h1
`define A_ISR 3'h2
`define A_LCR 3'h3
`define A_MCR 3'h4
`define A_LSR 3'h5
`define A_MSR 3'h6
`define A_SPR 3'h7
`define A_TRG 3'h0
`define A_FEATURE_CONTROL 3'h1
`define A_EFR 3'h2
`define A_RESUME_CHAR_ONE 3'h4
`define A_RESUME_CHAR_TWO 3'h5
`define A_PAUSE_CHAR_ONE 3'h6
`define A_PAUSE_CHAR_TWO 3'h7

`define FCR_EN_BIT 0
`define FCR_RXRST_BIT 1
`define FCR_TXRST_BIT 2
`define FCR_TXT_HI 5
`define FCR_TXT_LO 4
`define FCR_RXT_HI 7
`define FCR_RXT_LO 6

`define IER_RXDATA 0
`define IER_TXEMPTY 1
`define IER_LINE 2
`define IER_MODEM 3
`define IER_XOFF 5
`define IER_RTS 6
`define IER_CTS 7
`define IER_ENH_MASK 8'hF0
`define MCR_ENH_MASK 8'hE0

`define RX_DEPTH 7'h40
`define RX_ONE 7'h01
`define CNT_ZERO 7'h00
`define TRIG_0 7'h08
`define TRIG_1 7'h10
`define TRIG_2 7'h38
`define TRIG_3 7'h3C

`define ISR_NONE 8'h01
`define ISR_LINE 8'h06
`define ISR_RXDATA 8'h04
`define ISR_TXRDY 8'h02
`define ISR_MODEM 8'h00
`define ISR_XOFF 8'h10
`define ISR_FLOW 8'h20
`define ISR_FIFO_ON 2'h3
`define ISR_FIFO_OFF 2'h0

// Arbitrary identity values, neutral on purpose
`define REVISION_CODE 8'h01
`define DEVICE_CODE 8'h5C

`endif

// File: pkg/uart_regs_pkg.sv
// Types shared by the UART register block
package uart_regs_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [6:0] level_t;
	typedef enum logic [1:0] {
		BANK_NORMAL = 2'b00,
		BANK_DIVISOR = 2'b01,
		BANK_ENHANCED = 2'b10
	} bank_t;
endpackage : uart_regs_pkg

// File: rtl/rx_fill_tracker.sv
// Receive FIFO fill and error-character counters
`timescale 1ns/1ns
`include "uart_regs_cfg.svh"

module rx_fill_tracker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic push,
	input wire logic push_err,
	input wire logic pop,
	input wire logic pop_err,
	input wire uart_regs_pkg::level_t capacity,
	output uart_regs_pkg::level_t count_q,
	output uart_regs_pkg::level_t err_count_q,
	output logic overrun
);
	uart_regs_pkg::level_t count_d;
	uart_regs_pkg::level_t err_count_d;
	logic take;

	always_comb begin
		// A pop frees room in the same cycle, so push plus pop at full is no overrun
		take = push && (count_q < capacity || pop);
		overrun = push && !take;
		count_d = count_q;
		err_count_d = err_count_q;
		if (clear) begin
			count_d = `CNT_ZERO;
			err_count_d = `CNT_ZERO;
		end else begin
			count_d = count_q + (take ? `RX_ONE : `CNT_ZERO) - (pop ? `RX_ONE : `CNT_ZERO);
			err_count_d = err_count_q + ((take && push_err) ? `RX_ONE : `CNT_ZERO)
				- ((pop && pop_err && err_count_q != `CNT_ZERO) ? `RX_ONE : `CNT_ZERO);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_q <= `CNT_ZERO;
			err_count_q <= `CNT_ZERO;
		end else begin
			count_q <= count_d;
			err_count_q <= err_count_d;
		end
	end
endmodule : rx_fill_tracker

// File: rtl/uart_interrupt_status_regs.sv
// Host register map, interrupt masking and line status of one UART channel
// Overview of operation
// - Mask register gates rx data, tx empty, line and modem interrupts into source register.
// - Upper mask, source, fifo-control and modem-control bits act only with enhanced bit set.
// - FIFO mode with rx interrupt enabled: interrupt once fill reaches trigger level.
// - Rx data source code and interrupt drop when fill falls below trigger level.
// - Line status bit 0 sets when a character enters the FIFO, clears when empty.
// - Line status bit 1 flags a receive overrun.
// - Line status bits 2 to 4 give errors of the character at the holding register.
// - Line status bit 5 shows holding register empty, bit 6 FIFO and shifter empty.
// - Line status bit 7 sets while any FIFO character carries an error.
// - Divisor latch bit remaps addresses 0 and 1 to divisor low and high bytes.
// - Source bits 7 and 6 read one with FIFOs on, zero with FIFOs off.
// - Without FIFOs, rx data interrupt rises whenever the holding register has data.
`timescale 1ns/1ns
`include "uart_regs_cfg.svh"

module uart_interrupt_status_regs (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	input wire logic [7:0] rx_char,
	input wire logic rx_push,
	input wire logic rx_push_err,
	input wire logic rx_head_parity_err,
	input wire logic rx_head_framing_err,
	input wire logic rx_head_break,
	input wire logic thr_empty,
	input wire logic tx_all_empty,
	input wire logic [6:0] tx_level,
	input wire logic [7:0] msr_value,
	input wire logic msr_delta,
	input wire logic xoff_detected,
	input wire logic flow_change,
	output logic irq,
	output logic thr_write,
	output logic [7:0] thr_data,
	output logic rhr_read,
	output logic rx_fifo_reset,
	output logic tx_fifo_reset,
	output logic fifo_enable,
	output logic [1:0] tx_trigger_sel,
	output logic [15:0] divisor,
	output logic [7:0] line_control,
	output logic [7:0] modem_control,
	output logic [7:0] enhanced_function,
	output logic [7:0] feature_control,
	output logic [7:0] mode_select,
	output logic [7:0] fifo_trigger_level,
	output logic [7:0] resume_char_one,
	output logic [7:0] resume_char_two,
	output logic [7:0] pause_char_one,
	output logic [7:0] pause_char_two
);
	// Arbitrary identity values, neutral on purpose
	localparam uart_regs_pkg::byte_t REV_ID = `REVISION_CODE;
	localparam uart_regs_pkg::byte_t DEV_ID = `DEVICE_CODE;

	uart_regs_pkg::byte_t lcr_q, lcr_d, ier_q, ier_d, mcr_q, mcr_d, spr_q, spr_d;
	uart_regs_pkg::byte_t dll_q, dll_d, dlm_q, dlm_d, trg_q, trg_d, feature_control_q, feature_control_d;
	uart_regs_pkg::byte_t efr_q, efr_d, emsr_q, emsr_d;
	uart_regs_pkg::byte_t resume_char_one_q, resume_char_one_d, resume_char_two_q, resume_char_two_d, pause_char_one_q, pause_char_one_d, pause_char_two_q, pause_char_two_d;
	uart_regs_pkg::byte_t rd_data_q, rd_data_d, thr_data_q, thr_data_d, mcr_eff_q, mcr_eff_d;
	logic fifo_en_q, fifo_en_d;
	logic [1:0] rx_tsel_q, rx_tsel_d, tx_tsel_q, tx_tsel_d;
	logic thr_wr_q, thr_wr_d, rhr_rd_q, rhr_rd_d, rx_rst_q, rx_rst_d, tx_rst_q, tx_rst_d;
	logic ovr_q, ovr_d, tx_int_q, tx_int_d, thr_empty_prev_q, irq_q, irq_d;

	uart_regs_pkg::bank_t bank;
	uart_regs_pkg::byte_t ier_eff, isr_code, isr_value, lsr_value, read_mux;
	uart_regs_pkg::level_t rx_count, rx_err_count, rx_trigger, rx_capacity;
	logic enh, rd_ok, wr_ok, rx_pop, rx_overrun, head_err, rx_data_pend;
	logic line_pend, tx_pend, modem_pend, xoff_pend, flow_pend, dlab_id;

	function automatic uart_regs_pkg::level_t trig_of(input logic [1:0] sel);
		case (sel)
			2'h0: trig_of = `TRIG_0;
			2'h1: trig_of = `TRIG_1;
			2'h2: trig_of = `TRIG_2;
			default: trig_of = `TRIG_3;
		endcase
	endfunction : trig_of

	rx_fill_tracker u_rx_fill (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(rx_rst_q),
		.push(rx_push),
		.push_err(rx_push_err),
		.pop(rx_pop),
		.pop_err(head_err),
		.capacity(rx_capacity),
		.count_q(rx_count),
		.err_count_q(rx_err_count),
		.overrun(rx_overrun)
	);

	// Decode, status words and interrupt sources
	always_comb begin
		enh = efr_q[`EFR_ENH_BIT];
		if (lcr_q == `LCR_ENH_KEY)
			bank = uart_regs_pkg::BANK_ENHANCED;
		else if (lcr_q[`LCR_DLAB_BIT] && addr <= `A_IER)
			bank = uart_regs_pkg::BANK_DIVISOR;
		else
			bank = uart_regs_pkg::BANK_NORMAL;
		rd_ok = rd_strobe && !wr_strobe;
		wr_ok = wr_strobe;
		// Non-FIFO mode behaves as a one-deep holding register
		rx_capacity = fifo_en_q ? `RX_DEPTH : `RX_ONE;
		rx_pop = rd_ok && bank == uart_regs_pkg::BANK_NORMAL && addr == `A_DATA
			&& rx_count != `CNT_ZERO;
		head_err = rx_head_parity_err || rx_head_framing_err || rx_head_break;
		ier_eff = ier_q & (enh ? 8'hFF : ~`IER_ENH_MASK);
		rx_trigger = (feature_control_q[`FEATURE_CONTROL_TTAB_HI:`FEATURE_CONTROL_TTAB_LO] == `FEATURE_CONTROL_TTAB_PROG)
			? trg_q[6:0] : trig_of(rx_tsel_q);
		lsr_value = {
			rx_err_count != `CNT_ZERO,
			tx_all_empty,
			thr_empty,
			rx_count != `CNT_ZERO && rx_head_break,
			rx_count != `CNT_ZERO && rx_head_framing_err,
			rx_count != `CNT_ZERO && rx_head_parity_err,
			ovr_q,
			rx_count != `CNT_ZERO
		};
		line_pend = ier_eff[`IER_LINE] && (|lsr_value[4:1]);
		if (fifo_en_q)
			rx_data_pend = ier_eff[`IER_RXDATA] && rx_count >= rx_trigger;
		else
			rx_data_pend = ier_eff[`IER_RXDATA] && rx_count != `CNT_ZERO;
		tx_pend = ier_eff[`IER_TXEMPTY] && tx_int_q;
		modem_pend = ier_eff[`IER_MODEM] && msr_delta;
		xoff_pend = ier_eff[`IER_XOFF] && xoff_detected;
		flow_pend = (ier_eff[`IER_RTS] || ier_eff[`IER_CTS]) && flow_change;
		if (line_pend)
			isr_code = `ISR_LINE;
		else if (rx_data_pend)
			isr_code = `ISR_RXDATA;
		else if (tx_pend)
			isr_code = `ISR_TXRDY;
		else if (modem_pend)
			isr_code = `ISR_MODEM;
		else if (xoff_pend)
			isr_code = `ISR_XOFF;
		else if (flow_pend)
			isr_code = `ISR_FLOW;
		else
			isr_code = `ISR_NONE;
		isr_value = {fifo_en_q ? `ISR_FIFO_ON : `ISR_FIFO_OFF, isr_code[5:0]};
		dlab_id = dll_q == `RST_BYTE && dlm_q == `RST_BYTE;
		read_mux = `RST_BYTE;
		case (bank)
			uart_regs_pkg::BANK_DIVISOR: begin
				if (addr == `A_DATA)
					read_mux = dlab_id ? REV_ID : dll_q;
				else
					read_mux = dlab_id ? DEV_ID : dlm_q;
			end
			uart_regs_pkg::BANK_ENHANCED: begin
				case (addr)
					`A_TRG: read_mux = {1'b0, feature_control_q[`FEATURE_CONTROL_MODE_BIT] ? tx_level : rx_count};
					`A_FEATURE_CONTROL: read_mux = feature_control_q;
					`A_EFR: read_mux = efr_q;
					`A_LCR: read_mux = lcr_q;
					`A_RESUME_CHAR_ONE: read_mux = resume_char_one_q;
					`A_RESUME_CHAR_TWO: read_mux = resume_char_two_q;
					`A_PAUSE_CHAR_ONE: read_mux = pause_char_one_q;
					`A_PAUSE_CHAR_TWO: read_mux = pause_char_two_q;
					default: read_mux = `RST_BYTE;
				endcase
			end
			default: begin
				case (addr)
					`A_DATA: read_mux = rx_char;
					`A_IER: read_mux = ier_eff;
					`A_ISR: read_mux = isr_value;
					`A_LCR: read_mux = lcr_q;
					`A_MCR: read_mux = mcr_eff_q;
					`A_LSR: read_mux = lsr_value;
					`A_MSR: read_mux = msr_value;
					`A_SPR: read_mux = feature_control_q[`FEATURE_CONTROL_SWAP_BIT] ? {1'b0, rx_count} : spr_q;
					default: read_mux = `RST_BYTE;
				endcase
			end
		endcase
	end

	// Host-written registers and access pulses
	always_comb begin
		lcr_d = lcr_q;
		ier_d = ier_q;
		mcr_d = mcr_q;
		spr_d = spr_q;
		dll_d = dll_q;
		dlm_d = dlm_q;
		trg_d = trg_q;
		feature_control_d = feature_control_q;
		efr_d = efr_q;
		emsr_d = emsr_q;
		resume_char_one_d = resume_char_one_q;
		resume_char_two_d = resume_char_two_q;
		pause_char_one_d = pause_char_one_q;
		pause_char_two_d = pause_char_two_q;
		fifo_en_d = fifo_en_q;
		rx_tsel_d = rx_tsel_q;
		tx_tsel_d = tx_tsel_q;
		thr_data_d = thr_data_q;
		thr_wr_d = 1'b0;
		rx_rst_d = 1'b0;
		tx_rst_d = 1'b0;
		rhr_rd_d = rx_pop;
		rd_data_d = rd_ok ? read_mux : rd_data_q;
		if (wr_ok) begin
			case (bank)
				uart_regs_pkg::BANK_DIVISOR: begin
					if (addr == `A_DATA)
						dll_d = wr_data;
					else
						dlm_d = wr_data;
				end
				uart_regs_pkg::BANK_ENHANCED: begin
					case (addr)
						`A_TRG: trg_d = wr_data;
						`A_FEATURE_CONTROL: feature_control_d = wr_data;
						`A_EFR: efr_d = wr_data;
						`A_LCR: lcr_d = wr_data;
						`A_RESUME_CHAR_ONE: resume_char_one_d = wr_data;
						`A_RESUME_CHAR_TWO: resume_char_two_d = wr_data;
						`A_PAUSE_CHAR_ONE: pause_char_one_d = wr_data;
						`A_PAUSE_CHAR_TWO: pause_char_two_d = wr_data;
						default: lcr_d = lcr_q;
					endcase
				end
				default: begin
					case (addr)
						`A_DATA: begin
							thr_data_d = wr_data;
							thr_wr_d = 1'b1;
						end
						`A_IER: ier_d = wr_data;
						`A_ISR: begin
							fifo_en_d = wr_data[`FCR_EN_BIT];
							if (wr_data[`FCR_EN_BIT]) begin
								rx_rst_d = wr_data[`FCR_RXRST_BIT];
								tx_rst_d = wr_data[`FCR_TXRST_BIT];
								rx_tsel_d = wr_data[`FCR_RXT_HI:`FCR_RXT_LO];
								if (enh)
									tx_tsel_d = wr_data[`FCR_TXT_HI:`FCR_TXT_LO];
							end
						end
						`A_LCR: lcr_d = wr_data;
						`A_MCR: mcr_d = wr_data;
						`A_SPR: begin
							if (feature_control_q[`FEATURE_CONTROL_SWAP_BIT])
								emsr_d = wr_data;
							else
								spr_d = wr_data;
						end
						default: lcr_d = lcr_q;
					endcase
				end
			endcase
		end
	end

	// Sticky status, transmit-ready latch and interrupt line
	always_comb begin
		ovr_d = ovr_q;
		// Reading line status clears overrun, but a new overrun in that cycle wins
		if (rd_ok && bank == uart_regs_pkg::BANK_NORMAL && addr == `A_LSR)
			ovr_d = 1'b0;
		if (rx_overrun)
			ovr_d = 1'b1;
		tx_int_d = tx_int_q;
		if ((rd_ok && bank == uart_regs_pkg::BANK_NORMAL && addr == `A_ISR
			&& isr_code == `ISR_TXRDY) || thr_wr_d)
			tx_int_d = 1'b0;
		// Enabling the source while already empty raises it too
		if ((thr_empty && !thr_empty_prev_q)
			|| (thr_empty && wr_ok && bank == uart_regs_pkg::BANK_NORMAL && addr == `A_IER
			&& wr_data[`IER_TXEMPTY] && !ier_q[`IER_TXEMPTY]))
			tx_int_d = 1'b1;
		irq_d = isr_code != `ISR_NONE;
		mcr_eff_d = mcr_q & (enh ? 8'hFF : ~`MCR_ENH_MASK);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lcr_q <= `RST_BYTE;
			ier_q <= `RST_BYTE;
			mcr_q <= `RST_BYTE;
			spr_q <= `RST_BYTE;
			dll_q <= `RST_BYTE;
			dlm_q <= `RST_BYTE;
			trg_q <= `RST_BYTE;
			feature_control_q <= `RST_BYTE;
			efr_q <= `RST_BYTE;
			emsr_q <= `RST_BYTE;
			resume_char_one_q <= `RST_BYTE;
			resume_char_two_q <= `RST_BYTE;
			pause_char_one_q <= `RST_BYTE;
			pause_char_two_q <= `RST_BYTE;
			rd_data_q <= `RST_BYTE;
			thr_data_q <= `RST_BYTE;
			mcr_eff_q <= `RST_BYTE;
			fifo_en_q <= 1'b0;
			rx_tsel_q <= 2'h0;
			tx_tsel_q <= 2'h0;
			thr_wr_q <= 1'b0;
			rhr_rd_q <= 1'b0;
			rx_rst_q <= 1'b0;
			tx_rst_q <= 1'b0;
			ovr_q <= 1'b0;
			tx_int_q <= 1'b0;
			thr_empty_prev_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			lcr_q <= lcr_d;
			ier_q <= ier_d;
			mcr_q <= mcr_d;
			spr_q <= spr_d;
			dll_q <= dll_d;
			dlm_q <= dlm_d;
			trg_q <= trg_d;
			feature_control_q <= feature_control_d;
			efr_q <= efr_d;
			emsr_q <= emsr_d;
			resume_char_one_q <= resume_char_one_d;
			resume_char_two_q <= resume_char_two_d;
			pause_char_one_q <= pause_char_one_d;
			pause_char_two_q <= pause_char_two_d;
			rd_data_q <= rd_data_d;
			thr_data_q <= thr_data_d;
			mcr_eff_q <= mcr_eff_d;
			fifo_en_q <= fifo_en_d;
			rx_tsel_q <= rx_tsel_d;
			tx_tsel_q <= tx_tsel_d;
			thr_wr_q <= thr_wr_d;
			rhr_rd_q <= rhr_rd_d;
			rx_rst_q <= rx_rst_d;
			tx_rst_q <= tx_rst_d;
			ovr_q <= ovr_d;
			tx_int_q <= tx_int_d;
			thr_empty_prev_q <= thr_empty;
			irq_q <= irq_d;
		end
	end

	assign rd_data = rd_data_q;
	assign irq = irq_q;
	assign thr_write = thr_wr_q;
	assign thr_data = thr_data_q;
	assign rhr_read = rhr_rd_q;
	assign rx_fifo_reset = rx_rst_q;
	assign tx_fifo_reset = tx_rst_q;
	assign fifo_enable = fifo_en_q;
	assign tx_trigger_sel = tx_tsel_q;
	assign divisor = {dlm_q, dll_q};
	assign line_control = lcr_q;
	assign modem_control = mcr_eff_q;
	assign enhanced_function = efr_q;
	assign feature_control = feature_control_q;
	assign mode_select = emsr_q;
	assign fifo_trigger_level = trg_q;
	assign resume_char_one = resume_char_one_q;
	assign resume_char_two = resume_char_two_q;
	assign pause_char_one = pause_char_one_q;
	assign pause_char_two = pause_char_two_q;
endmodule : uart_interrupt_status_regs

// File: bench/uart_regs_chk.sv
// Assertions on the register block's host and control ports
`timescale 1ns/1ns
module uart_regs_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic wr_strobe,
	input wire logic [7:0] wr_data,
	input wire logic thr_write,
	input wire logic rd_strobe,
	input wire logic rhr_read,
	input wire logic [7:0] fifo_trigger_level,
	input wire logic [7:0] thr_data,
	input wire logic [15:0] divisor,
	input wire logic [7:0] line_control,
	input wire logic [7:0] modem_control,
	input wire logic [7:0] enhanced_function,
	input wire logic [7:0] resume_char_one,
	input wire logic rx_fifo_reset,
	input wire logic tx_fifo_reset,
	input wire logic fifo_enable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic wr_enh;
	logic wr_low;
	logic wr_div;
	assign wr_enh = wr_strobe && line_control == 8'hBF;
	assign wr_low = wr_strobe && !line_control[7];
	assign wr_div = wr_strobe && line_control[7] && !wr_enh;

	a_thr_pulse: assert property (
		wr_low && addr == 3'h0 |=> thr_write && thr_data == $past(wr_data))
		else $error("data write gave no transmit pulse");
	a_div_low: assert property (
		wr_div && addr == 3'h0 |=> divisor[7:0] == $past(wr_data) && !thr_write)
		else $error("divisor low byte not written");
	a_div_high: assert property (
		wr_div && addr == 3'h1 |=> divisor[15:8] == $past(wr_data))
		else $error("divisor high byte not written");
	a_enh_efr: assert property (
		wr_enh && addr == 3'h2 |=> enhanced_function == $past(wr_data))
		else $error("enhanced function not written");
	a_enh_no_thr: assert property (
		wr_enh && addr == 3'h0 |=> !thr_write)
		else $error("trigger write leaked to transmitter");
	a_trg_wr: assert property (
		wr_enh && addr == 3'h0 |=> fifo_trigger_level == $past(wr_data))
		else $error("trigger level not written");
	a_rhr_pulse: assert property (
		rhr_read |-> $past(rd_strobe && !wr_strobe && addr == 3'h0 && !line_control[7]))
		else $error("holding read pulse without data read");
	a_resume_wr: assert property (
		wr_enh && addr == 3'h4 |=> resume_char_one == $past(wr_data))
		else $error("resume character not written");
	a_mcr_masked: assert property (
		!enhanced_function[4] && !$past(enhanced_function[4]) |-> modem_control[7:5] == 3'h0)
		else $error("modem control upper bits active");
	a_fcr_ignored: assert property (
		wr_low && addr == 3'h2 && !wr_data[0]
		|=> !rx_fifo_reset && !tx_fifo_reset && !fifo_enable)
		else $error("fifo control acted without enable");
	a_fcr_reset: assert property (
		wr_low && addr == 3'h2 && wr_data[1:0] == 2'h3 |=> rx_fifo_reset && fifo_enable)
		else $error("receive fifo reset missing");
endmodule : uart_regs_chk

// File: bench/host_bus_model.sv
// Host processor model driving the register bus
`timescale 1ns/1ns
module host_bus_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] rd_data,
	output logic [2:0] addr,
	output logic wr_strobe,
	output logic rd_strobe,
	output logic [7:0] wr_data
);
	logic [7:0] exp_q[$];
	logic taken = 1'b0;
	initial begin
		addr = 3'h0;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		wr_data = 8'h00;
	end
	// Idle bus shows inverted values so stale data never looks valid
	// Callers toggle fifo enable and the low mask bits between checks
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge ref_clk);
		wr_strobe <= 1'b0;
		addr <= ~a;
		wr_data <= ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_strobe <= 1'b1;
		exp_q.push_back(e);
		@(posedge ref_clk);
		rd_strobe <= 1'b0;
		addr <= ~a;
	endtask : rd
	always @(posedge ref_clk) taken <= rd_strobe & ~wr_strobe & ~rst;
	// Read data is settled by the falling edge after the read
	always @(negedge ref_clk) begin
		if (taken && exp_q.size() > 0)
			tb.check(rd_data, exp_q.pop_front());
	end
endmodule : host_bus_model

// File: bench/tb.sv
// Self-checking testbench for the UART register block
`timescale 1ns/1ns
`include "uart_regs_cfg.svh"
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr;
	logic wr_strobe;
	logic rd_strobe;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] rx_char = 8'h00;
	logic [7:0] msr_value = 8'h00;
	logic [7:0] r;
	logic rx_push = 1'b0;
	logic rx_push_err = 1'b0;
	logic par_err = 1'b0;
	logic thr_empty = 1'b1;
	logic tx_all_empty = 1'b1;
	logic msr_delta = 1'b0;
	logic irq;
	int n_errors = 0;
	int num_checks = 0;
	always #50 ref_clk = ~ref_clk;

	host_bus_model host (.ref_clk(ref_clk), .rst(rst), .rd_data(rd_data), .addr(addr),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data));
	uart_interrupt_status_regs i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data), .rd_data(rd_data),
		.rx_char(rx_char), .rx_push(rx_push), .rx_push_err(rx_push_err),
		.rx_head_parity_err(par_err), .rx_head_framing_err(1'b0), .rx_head_break(1'b0),
		.thr_empty(thr_empty), .tx_all_empty(tx_all_empty), .tx_level(7'h00),
		.msr_value(msr_value), .msr_delta(msr_delta), .xoff_detected(1'b0),
		.flow_change(1'b0), .irq(irq), .thr_write(), .thr_data(), .rhr_read(),
		.rx_fifo_reset(), .tx_fifo_reset(), .fifo_enable(), .tx_trigger_sel(), .divisor(),
		.line_control(), .modem_control(), .enhanced_function(), .feature_control(),
		.mode_select(), .fifo_trigger_level(), .resume_char_one(), .resume_char_two(),
		.pause_char_one(), .pause_char_two());

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// Each cycle with the push held high moves one character in, unless the FIFO is already full
	task automatic push(input int n, input logic err);
		@(posedge ref_clk);
		rx_push <= 1'b1;
		rx_push_err <= err;
		repeat (n) @(posedge ref_clk);
		rx_push <= 1'b0;
		rx_push_err <= 1'b0;
	endtask : push
	// Interrupt output lags its source by a cycle
	task automatic irq_is(input logic e);
		repeat (2) @(posedge ref_clk);
		#1 check({7'h00, irq}, {7'h00, e});
	endtask : irq_is

	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		stop_test();
	end

	initial begin
		void'($urandom(55));
		rx_char <= 8'($urandom);
		msr_value <= 8'($urandom);
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		host.rd(`A_LCR, 8'h00);
		host.rd(`A_LSR, 8'h60);
		host.rd(`A_ISR, `ISR_NONE);
		host.rd(`A_MSR, msr_value);
		host.wr(`A_IER, 8'h01);
		push(1, 1'b0);
		irq_is(1'b1);
		host.rd(`A_ISR, `ISR_RXDATA);
		host.rd(`A_DATA, rx_char);
		irq_is(1'b0);
		host.wr(`A_IER, 8'h02);
		host.rd(`A_ISR, `ISR_TXRDY);
		host.rd(`A_ISR, `ISR_NONE);
		msr_delta <= 1'b1;
		host.wr(`A_IER, 8'h08);
		host.rd(`A_ISR, `ISR_MODEM);
		host.wr(`A_IER, 8'h05);
		host.rd(`A_ISR, `ISR_NONE);
		msr_delta <= 1'b0;
		host.wr(`A_LCR, 8'h80);
		host.rd(`A_DATA, `REVISION_CODE);
		host.rd(`A_IER, `DEVICE_CODE);
		// Nonzero, or the identity read would shadow the divisor read-back
		r = 8'($urandom) | 8'h01;
		host.wr(`A_DATA, r);
		host.rd(`A_DATA, r);
		host.wr(`A_IER, ~r);
		host.rd(`A_IER, ~r);
		host.wr(`A_LCR, `LCR_ENH_KEY);
		host.wr(`A_EFR, 8'h10);
		for (int a = 4; a < 8; a++) begin
			r = 8'($urandom);
			host.wr(3'(a), r);
			host.rd(3'(a), r);
		end
		host.rd(`A_EFR, 8'h10);
		host.wr(`A_LCR, 8'h03);
		host.rd(`A_IER, 8'h05);
		host.wr(`A_IER, 8'hF0);
		host.rd(`A_IER, 8'hF0);
		host.wr(`A_MCR, 8'hFF);
		host.rd(`A_MCR, 8'hFF);
		host.wr(`A_LCR, `LCR_ENH_KEY);
		host.wr(`A_EFR, 8'h00);
		host.wr(`A_LCR, 8'h03);
		host.rd(`A_IER, 8'h00);
		host.rd(`A_MCR, 8'h1F);
		host.wr(`A_ISR, 8'h00);
		host.rd(`A_ISR, `ISR_NONE);
		host.wr(`A_ISR, 8'h03);
		host.rd(`A_ISR, 8'hC1);
		host.wr(`A_IER, 8'h01);
		push(6, 1'b0);
		push(1, 1'b1);
		host.rd(`A_LSR, 8'hE1);
		irq_is(1'b0);
		push(1, 1'b0);
		irq_is(1'b1);
		host.rd(`A_ISR, 8'hC4);
		host.rd(`A_DATA, rx_char);
		irq_is(1'b0);
		host.rd(`A_ISR, 8'hC1);
		par_err <= 1'b1;
		thr_empty <= 1'b0;
		tx_all_empty <= 1'b0;
		host.rd(`A_LSR, 8'h85);
		par_err <= 1'b0;
		thr_empty <= 1'b1;
		tx_all_empty <= 1'b1;
		host.wr(`A_IER, 8'h00);
		push(58, 1'b0);
		irq_is(1'b0);
		host.wr(`A_IER, 8'h04);
		host.rd(`A_ISR, 8'hC6);
		host.rd(`A_LSR, 8'hE3);
		host.rd(`A_LSR, 8'hE1);
		host.wr(`A_ISR, 8'h03);
		host.rd(`A_LSR, 8'h60);
		host.wr(`A_LCR, `LCR_ENH_KEY);
		host.wr(`A_FEATURE_CONTROL, 8'h30);
		host.wr(`A_TRG, 8'h03);
		host.rd(`A_FEATURE_CONTROL, 8'h30);
		host.wr(`A_LCR, 8'h03);
		host.wr(`A_IER, 8'h01);
		push(2, 1'b0);
		irq_is(1'b0);
		push(1, 1'b0);
		irq_is(1'b1);
		host.wr(`A_LCR, `LCR_ENH_KEY);
		host.rd(`A_TRG, 8'h03);
		// The last read is compared on the following falling edge
		repeat (2) @(posedge ref_clk);
		stop_test();
	end
endmodule : tb

bind uart_interrupt_status_regs uart_regs_chk i_chk (.ref_clk(ref_clk), .rst(rst),
	.addr(addr), .wr_strobe(wr_strobe), .wr_data(wr_data), .thr_write(thr_write),
	.rd_strobe(rd_strobe), .rhr_read(rhr_read), .fifo_trigger_level(fifo_trigger_level),
	.thr_data(thr_data), .divisor(divisor), .line_control(line_control),
	.modem_control(modem_control), .enhanced_function(enhanced_function),
	.resume_char_one(resume_char_one), .rx_fifo_reset(rx_fifo_reset),
	.tx_fifo_reset(tx_fifo_reset), .fifo_enable(fifo_enable));
